// ==== acdr_pkg.sv ====
// Constants, types and register map for the asynchronous receive recovery block
package acdr_pkg;
	// Register byte offsets
	localparam logic [4:0]  OFS_RXDATA   = 5'h00;
	localparam logic [4:0]  OFS_STATUS   = 5'h04;
	localparam logic [4:0]  OFS_CTRL_TWO = 5'h08;
	localparam logic [4:0]  OFS_FORMAT   = 5'h0C;
	localparam logic [4:0]  OFS_BAUD     = 5'h10;
	// Field positions
	localparam int          RXD_FERR_BIT = 14;
	localparam int          RXD_VLD_BIT  = 15;
	localparam int          ST_RXC_BIT   = 0;
	localparam int          ST_FERR_BIT  = 1;
	localparam int          ST_ISF_BIT   = 2;
	localparam int          ST_BRK_BIT   = 3;
	localparam int          CT_EN_BIT    = 0;
	localparam int          CT_MODE_LSB  = 1;
	localparam int          FMT_PAR_BIT  = 3;
	// Reset values
	localparam logic [15:0] BAUD_RESET   = 16'h0800;
	localparam logic [2:0]  CTRL_RESET   = 3'h0;
	localparam logic [3:0]  FMT_RESET    = 4'h3;
	// Receive modes held in ctrl_ff[2:1]
	localparam logic [1:0]  MODE_NORMAL  = 2'h0;
	localparam logic [1:0]  MODE_DOUBLE  = 2'h1;
	localparam logic [1:0]  MODE_GENERIC = 2'h2;
	localparam logic [1:0]  MODE_CONSTR  = 2'h3;
	// Oversampling and voting
	localparam logic [4:0]  SPB_NORMAL   = 5'h10;
	localparam logic [4:0]  SPB_DOUBLE   = 5'h08;
	localparam logic [4:0]  FIRST_VOTE_NORMAL = 5'h08;
	localparam logic [4:0]  FIRST_VOTE_DOUBLE = 5'h04;
	localparam logic [4:0]  VOTE_SPAN    = 5'h02;
	localparam logic [3:0]  MIN_BITS     = 4'h5;
	localparam logic [3:0]  MAX_BITS     = 4'hA;
	// Sample step of the fractional rate generator: divisor counts clocks per eight bits in normal mode, per sixteen in double speed
	localparam logic [7:0]  SAMPLE_STEP  = 8'h80;
	// Automatic baud
	localparam logic [3:0]  BREAK_SAMPLES = 4'hC;
	localparam logic [2:0]  SYNC_FALLS   = 3'h4;
	localparam logic [15:0] DIV_MIN      = 16'h0064;
	localparam logic [16:0] DIV_MAX      = 17'h0FFFF;
	localparam int          SYNC_TOL_SHIFT = 3;
	// AXI responses
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE, ST_START, ST_DATA, ST_STOP, ST_SYNC_WAIT, ST_SYNC_MEAS, ST_SETTLE
	} acdr_state_t;
endpackage : acdr_pkg

// ==== acdr_rate_if.sv ====
// Divisor and sample tick shared between the receiver and its rate generator
interface acdr_rate_if;
	logic [15:0] divisor;
	logic        sample_tick;
	modport gen (input divisor, output sample_tick);
	modport use_side (output divisor, input sample_tick);
endinterface : acdr_rate_if

// ==== acdr_rate_gen.sv ====
// Fractional oversample tick generator
module acdr_rate_gen
	import acdr_pkg::*;
(
	input  wire logic  i_core_clk,
	input  wire logic  i_rst_n,
	acdr_rate_if.gen   rate
);
	logic [16:0] acc_ff;
	logic [16:0] sum;
	logic        tick_ff;

	// Same tick rate in both speeds: double speed halves the samples per bit instead
	assign sum = acc_ff + {9'h000, SAMPLE_STEP};
	assign rate.sample_tick = tick_ff;

	// Divisors below one step saturate at one tick per clock
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			acc_ff  <= 17'h00000;
			tick_ff <= 1'b0;
		end
		else if (sum >= {1'b0, rate.divisor})
		begin
			acc_ff  <= (sum - {1'b0, rate.divisor} >= {1'b0, rate.divisor}) ? 17'h00000
				: sum - {1'b0, rate.divisor};
			tick_ff <= 1'b1;
		end
		else
		begin
			acc_ff  <= sum;
			tick_ff <= 1'b0;
		end
	end
endmodule : acdr_rate_gen

// ==== acdr_rx_top.sv ====
// Asynchronous receive clock and data recovery with AXI4-Lite registers
module acdr_rx_top
	import acdr_pkg::*;
#(
	parameter int ADDR_W = 8
)(
	input  wire logic                i_core_clk,
	input  wire logic                i_rst_n,
	input  wire logic                i_rxd,
	input  wire logic [ADDR_W-1:0]   i_s_axi_awaddr,
	input  wire logic                i_s_axi_awvalid,
	output logic                     o_s_axi_awready,
	input  wire logic [31:0]         i_s_axi_wdata,
	input  wire logic [3:0]          i_s_axi_wstrb,
	input  wire logic                i_s_axi_wvalid,
	output logic                     o_s_axi_wready,
	output logic [1:0]               o_s_axi_bresp,
	output logic                     o_s_axi_bvalid,
	input  wire logic                i_s_axi_bready,
	input  wire logic [ADDR_W-1:0]   i_s_axi_araddr,
	input  wire logic                i_s_axi_arvalid,
	output logic                     o_s_axi_arready,
	output logic [31:0]              o_s_axi_rdata,
	output logic [1:0]               o_s_axi_rresp,
	output logic                     o_s_axi_rvalid,
	input  wire logic                i_s_axi_rready,
	output logic [9:0]               o_rx_data,
	output logic                     o_rx_valid,
	output logic                     o_frame_err
);
	import acdr_pkg::*;

	// Too narrow an address cannot reach every register
	if (ADDR_W < 5)
	begin : g_addr_w_check
		$error("ADDR_W must cover the register map");
	end

	acdr_rate_if rate ();

	// Pin synchroniser and filtered level
	logic        sync1_ff, sync2_ff, sync3_ff, rx_ff, rx_d_ff, rx_prev_ff;
	// Registers
	logic [2:0]  ctrl_ff;
	logic [3:0]  fmt_ff;
	logic [15:0] baud_ff;
	logic        rxc_ff, ferr_ff, isf_ff, brk_ff;
	logic [9:0]  rxd_ff;
	logic        rxd_ferr_ff;
	// Bus state
	logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic        aw_have_ff, w_have_ff;
	logic [4:0]  waddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	// Frame engine
	acdr_state_t state_ff;
	logic [4:0]  samp_ff;
	logic [1:0]  vote_ff;
	logic [3:0]  bitcnt_ff;
	logic [9:0]  shift_ff;
	logic [3:0]  lowcnt_ff;
	logic [16:0] meas_ff;
	logic [16:0] first_ff;
	logic [2:0]  falls_ff;
	logic [9:0]  out_data_ff;
	logic        out_vld_ff, out_ferr_ff;

	logic [1:0]  mode;
	logic        dbl, autob, tick, fall, maj, do_write, do_read, rx_done, sync_end;
	logic [4:0]  spb, first_idx, cur;
	logic [3:0]  bits_total;
	logic [16:0] total, diff;
	logic        in_range, consistent, upd_baud, brk_hit;
	logic [31:0] wmask;

	acdr_rate_gen u_rate (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.rate       (rate.gen)
	);

	// Mode decode and per-mode sampling geometry
	assign mode       = ctrl_ff[CT_MODE_LSB +: 2];
	assign dbl        = (mode == MODE_DOUBLE);
	assign autob      = (mode == MODE_GENERIC) || (mode == MODE_CONSTR);
	assign spb        = dbl ? SPB_DOUBLE : SPB_NORMAL;
	assign first_idx  = dbl ? FIRST_VOTE_DOUBLE : FIRST_VOTE_NORMAL;
	assign bits_total = MIN_BITS + {1'b0, fmt_ff[2:0]} + {3'h0, fmt_ff[FMT_PAR_BIT]};
	assign tick       = rate.sample_tick;
	assign rate.divisor = baud_ff;
	assign cur        = samp_ff + 5'h01;
	assign fall       = rx_d_ff & ~rx_ff;
	// Majority of the two held votes and the present sample
	assign maj        = (vote_ff[0] & vote_ff[1]) | (rx_ff & (vote_ff[0] | vote_ff[1]));
	assign rx_done    = tick && (state_ff == ST_STOP) && (cur == first_idx + VOTE_SPAN);
	assign sync_end   = (state_ff == ST_SYNC_MEAS) && fall && (falls_ff == SYNC_FALLS - 3'h1);
	// Sync bits at the old rate can span twelve samples, so a break cannot cut a measurement short
	assign brk_hit    = autob && tick && (lowcnt_ff >= BREAK_SAMPLES)
		&& (state_ff != ST_SYNC_MEAS) && (state_ff != ST_SETTLE);

	// Sync-field measurement checks
	assign total      = meas_ff + 17'h00001;
	assign diff       = ({first_ff[14:0], 2'b00} > total) ? {first_ff[14:0], 2'b00} - total
		: total - {first_ff[14:0], 2'b00};
	assign in_range   = (total >= {1'b0, DIV_MIN}) && (total <= DIV_MAX);
	assign consistent = in_range && (diff <= (total >> SYNC_TOL_SHIFT));
	assign upd_baud   = sync_end && ((mode == MODE_GENERIC) ? in_range : consistent);

	assign do_write   = aw_have_ff && w_have_ff && !bvalid_ff;
	assign do_read    = i_s_axi_arvalid && arready_ff;
	assign wmask      = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

	// Three-stage pin capture; the level moves only when stages two and three agree
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			sync3_ff <= 1'b1;
			rx_ff    <= 1'b1;
			rx_d_ff  <= 1'b1;
		end
		else
		begin
			sync1_ff <= i_rxd;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			rx_ff    <= (sync2_ff == sync3_ff) ? sync3_ff : rx_ff;
			rx_d_ff  <= rx_ff;
		end
	end

	// Consecutive low samples for break detection, saturating
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			lowcnt_ff  <= 4'h0;
			rx_prev_ff <= 1'b1;
		end
		else if (tick)
		begin
			rx_prev_ff <= rx_ff;
			if (rx_ff)
				lowcnt_ff <= 4'h0;
			else if (lowcnt_ff != 4'hF)
				lowcnt_ff <= lowcnt_ff + 4'h1;
		end
	end

	// Frame engine: start qualification, bit voting, stop check and sync measurement
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_ff  <= ST_IDLE;
			samp_ff   <= 5'h00;
			vote_ff   <= 2'b11;
			bitcnt_ff <= 4'h0;
			shift_ff  <= 10'h000;
			meas_ff   <= 17'h00000;
			first_ff  <= 17'h00000;
			falls_ff  <= 3'h0;
		end
		else if (!ctrl_ff[CT_EN_BIT])
			state_ff <= ST_IDLE;
		else if (brk_hit && (state_ff != ST_SYNC_WAIT))
			state_ff <= ST_SYNC_WAIT; // abandon any frame; a sync character follows
		else
		begin
			case (state_ff)
				ST_IDLE:
					if (tick && rx_prev_ff && !rx_ff)
					begin
						state_ff <= ST_START;
						samp_ff  <= 5'h01;
					end
				ST_START, ST_DATA, ST_STOP:
					if (tick)
					begin
						samp_ff <= (cur == spb) ? 5'h00 : cur;
						if ((cur >= first_idx) && (cur < first_idx + VOTE_SPAN))
							vote_ff <= {vote_ff[0], rx_ff};
						if (cur == first_idx + VOTE_SPAN)
						begin
							if (state_ff == ST_START && maj)
								state_ff <= ST_IDLE;
							else if (state_ff == ST_DATA)
							begin
								shift_ff  <= {maj, shift_ff[9:1]};
								bitcnt_ff <= bitcnt_ff + 4'h1;
							end
							else if (state_ff == ST_STOP)
								state_ff <= ST_IDLE;
						end
						if (cur == spb)
						begin
							if (state_ff == ST_START)
							begin
								state_ff  <= ST_DATA;
								bitcnt_ff <= 4'h0;
							end
							else if (state_ff == ST_DATA && bitcnt_ff == bits_total)
								state_ff <= ST_STOP;
						end
					end
				ST_SYNC_WAIT:
					if (fall)
					begin
						state_ff <= ST_SYNC_MEAS;
						meas_ff  <= 17'h00000;
						falls_ff <= 3'h0;
					end
				ST_SYNC_MEAS:
				begin
					meas_ff <= meas_ff + 17'h00001;
					if (fall)
					begin
						falls_ff <= falls_ff + 3'h1;
						if (falls_ff == 3'h0)
							first_ff <= meas_ff;
					end
					if (sync_end || meas_ff > DIV_MAX)
						state_ff <= ST_SETTLE;
				end
				// Leave on a high sample so the low run count is cleared before idle looks again
				ST_SETTLE:
					if (tick && rx_ff)
						state_ff <= ST_IDLE;
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end

	// Delivered word, right aligned to the configured frame size
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			out_data_ff <= 10'h000;
			out_vld_ff  <= 1'b0;
			out_ferr_ff <= 1'b0;
		end
		else
		begin
			out_vld_ff <= rx_done;
			if (rx_done)
			begin
				out_data_ff <= shift_ff >> (MAX_BITS - bits_total);
				out_ferr_ff <= ~maj;
			end
		end
	end

	// Software-written control, format and divisor; sync measurement overrides the divisor
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ctrl_ff <= CTRL_RESET;
			fmt_ff  <= FMT_RESET;
			baud_ff <= BAUD_RESET;
		end
		else
		begin
			if (do_write && waddr_ff == OFS_CTRL_TWO && wstrb_ff[0])
				ctrl_ff <= wdata_ff[2:0];
			if (do_write && waddr_ff == OFS_FORMAT && wstrb_ff[0])
				fmt_ff <= (wdata_ff[2:0] > 3'h4) ? {wdata_ff[FMT_PAR_BIT], 3'h4} : wdata_ff[3:0];
			if (upd_baud)
				baud_ff <= total[15:0];
			else if (do_write && waddr_ff == OFS_BAUD)
				baud_ff <= (baud_ff & ~wmask[15:0]) | (wdata_ff[15:0] & wmask[15:0]);
		end
	end

	// Receive holding word and status flags; a setting event beats a clear in the same cycle
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rxd_ff      <= 10'h000;
			rxd_ferr_ff <= 1'b0;
			rxc_ff      <= 1'b0;
			ferr_ff     <= 1'b0;
			isf_ff      <= 1'b0;
			brk_ff      <= 1'b0;
		end
		else
		begin
			if (out_vld_ff)
			begin
				rxd_ff      <= out_data_ff;
				rxd_ferr_ff <= out_ferr_ff;
			end
			rxc_ff  <= out_vld_ff | (rxc_ff & ~(do_read && i_s_axi_araddr[4:0] == OFS_RXDATA));
			ferr_ff <= (out_vld_ff & out_ferr_ff)
				| (ferr_ff & ~(do_write && waddr_ff == OFS_STATUS && wdata_ff[ST_FERR_BIT]));
			isf_ff  <= (sync_end && mode == MODE_CONSTR && !consistent)
				| (isf_ff & ~(do_write && waddr_ff == OFS_STATUS && wdata_ff[ST_ISF_BIT]));
			brk_ff  <= brk_hit
				| (brk_ff & ~(do_write && waddr_ff == OFS_STATUS && wdata_ff[ST_BRK_BIT]));
		end
	end

	// Write channel: address and data are taken in either order, response follows both
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			waddr_ff   <= 5'h00;
			wdata_ff   <= 32'h00000000;
			wstrb_ff   <= 4'h0;
		end
		else
		begin
			if (i_s_axi_awvalid && awready_ff)
			begin
				waddr_ff   <= i_s_axi_awaddr[4:0];
				aw_have_ff <= 1'b1;
				awready_ff <= 1'b0;
			end
			if (i_s_axi_wvalid && wready_ff)
			begin
				wdata_ff  <= i_s_axi_wdata;
				wstrb_ff  <= i_s_axi_wstrb;
				w_have_ff <= 1'b1;
				wready_ff <= 1'b0;
			end
			if (do_write)
			begin
				bvalid_ff  <= 1'b1;
				aw_have_ff <= 1'b0;
				w_have_ff  <= 1'b0;
				bresp_ff   <= (waddr_ff == OFS_STATUS || waddr_ff == OFS_CTRL_TWO || waddr_ff == OFS_FORMAT
					|| waddr_ff == OFS_BAUD || waddr_ff == OFS_RXDATA) ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_ff && i_s_axi_bready)
			begin
				bvalid_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
		end
	end

	// Read channel: one read in flight; reading the receive word pops it
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h00000000;
			rresp_ff   <= RESP_OKAY;
		end
		else if (do_read)
		begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rresp_ff   <= RESP_OKAY;
			case (i_s_axi_araddr[4:0])
				OFS_RXDATA:   rdata_ff <= {16'h0000, rxc_ff, rxd_ferr_ff, 4'h0, rxd_ff};
				OFS_STATUS:   rdata_ff <= {28'h0000000, brk_ff, isf_ff, ferr_ff, rxc_ff};
				OFS_CTRL_TWO: rdata_ff <= {29'h00000000, ctrl_ff};
				OFS_FORMAT:   rdata_ff <= {28'h0000000, fmt_ff};
				OFS_BAUD:     rdata_ff <= {16'h0000, baud_ff};
				default:
				begin
					rdata_ff <= 32'h00000000;
					rresp_ff <= RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_ff && i_s_axi_rready)
		begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	assign o_s_axi_awready = awready_ff;
	assign o_s_axi_wready  = wready_ff;
	assign o_s_axi_bvalid  = bvalid_ff;
	assign o_s_axi_bresp   = bresp_ff;
	assign o_s_axi_arready = arready_ff;
	assign o_s_axi_rvalid  = rvalid_ff;
	assign o_s_axi_rdata   = rdata_ff;
	assign o_s_axi_rresp   = rresp_ff;
	assign o_rx_data       = out_data_ff;
	assign o_rx_valid      = out_vld_ff;
	assign o_frame_err     = out_ferr_ff;
endmodule : acdr_rx_top

// ==== acdr_rx_props.sv ====
// Checker for bus handshakes and frame outputs of the receive recovery block
module acdr_rx_props
	import acdr_pkg::*;
(
	input wire logic        i_core_clk,
	input wire logic        i_rst_n,
	input wire logic        i_s_axi_awvalid,
	input wire logic        o_s_axi_awready,
	input wire logic        i_s_axi_wvalid,
	input wire logic        o_s_axi_wready,
	input wire logic [1:0]  o_s_axi_bresp,
	input wire logic        o_s_axi_bvalid,
	input wire logic        i_s_axi_bready,
	input wire logic        i_s_axi_arvalid,
	input wire logic        o_s_axi_arready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic [1:0]  o_s_axi_rresp,
	input wire logic        o_s_axi_rvalid,
	input wire logic        i_s_axi_rready,
	input wire logic [9:0]  o_rx_data,
	input wire logic        o_rx_valid,
	input wire logic        o_frame_err
);
	// Single domain, so one clock and one reset serve every property
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	// Read answer comes right after the address is taken
	AST_AR_TO_RVALID: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && !o_s_axi_arready)
		else $error("read answer not one cycle after address");
	AST_R_HOLD: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
		else $error("read answer dropped or changed before ready");
	AST_RESP_CODE: assert property (o_s_axi_rvalid |-> o_s_axi_rresp == RESP_OKAY || o_s_axi_rresp == RESP_SLVERR)
		else $error("illegal read response code");
	// Write answer two edges after address and data are taken together
	AST_W_TO_BVALID: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
		|=> !o_s_axi_bvalid ##1 o_s_axi_bvalid)
		else $error("write answer timing wrong");
	AST_B_HOLD: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
		else $error("write answer dropped before ready");
	AST_W_BLOCKED: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("second write accepted while answer pending");
	// One result per frame: a frame is far longer than eight clocks
	AST_RX_PULSE: assert property (o_rx_valid |=> !o_rx_valid [*8])
		else $error("frame complete pulse too long or repeated");
	AST_RX_HOLD: assert property (!$stable(o_rx_data) || !$stable(o_frame_err) |-> o_rx_valid)
		else $error("frame outputs changed without a completed frame");
endmodule : acdr_rx_props

bind acdr_rx_top acdr_rx_props acdr_rx_props_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
	.i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wvalid(i_s_axi_wvalid),
	.o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
	.i_s_axi_bready(i_s_axi_bready), .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
	.o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
	.i_s_axi_rready(i_s_axi_rready), .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .o_frame_err(o_frame_err));

// ==== acdr_uart_tx_model.sv ====
// Behavioural remote asynchronous transmitter driving the receive line
module acdr_uart_tx_model
(
	input  wire logic i_core_clk,
	output logic      o_line
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_line = 1'h1;

	// Hold a level for a number of clocks, changed just after an edge
	task automatic hold(input logic lvl, input int clks);
		@(posedge i_core_clk);
		o_line <= lvl;
		repeat (clks - 1) @(posedge i_core_clk);
	endtask : hold

	// Start, bits first-bit-first, stop; exact bit time keeps our rate error at zero
	task automatic send(input logic [9:0] bits, input int n, input int bt, input int extra,
		input logic stop, input int stop_clks);
		hold(1'h0, bt + extra);
		for (int i = 0; i < n; i++)
			hold(bits[i], bt);
		// Long high stop doubles as extra stop bits and delays the next start
		hold(stop, stop_clks);
		// A low stop must return to idle, or it would run on into a break
		if (!stop)
			hold(1'h1, bt);
	endtask : send
endmodule : acdr_uart_tx_model

// ==== acdr_rx_tb_top.sv ====
// Self-checking bench for the asynchronous receive recovery block
module acdr_rx_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import acdr_pkg::*;

	typedef struct packed {logic [1:0] mode; logic [3:0] fmt; logic [9:0] data; logic stop;} acdr_row_t;
	logic        i_core_clk = 1'h0, i_rst_n = 1'h0, i_rxd;
	logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
	logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, rd, base;
	logic        i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
	logic        i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0;
	logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	logic        o_rx_valid, o_frame_err;
	logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, resp;
	logic [9:0]  o_rx_data, want;
	logic [10:0] rxq[$];
	int          n_errors = 0, cmp_count = 0, cycles = 0, n, bt;
	// Ordinary frames: mode, format, data, stop level
	acdr_row_t   rows [5] = '{'{MODE_NORMAL, 4'h3, 10'h0A5, 1'h1}, '{MODE_NORMAL, 4'h0, 10'h015, 1'h0},
		'{MODE_NORMAL, 4'hC, 10'h2D3, 1'h1}, '{MODE_DOUBLE, 4'h3, 10'h03C, 1'h1}, '{MODE_DOUBLE, 4'h2, 10'h05A, 1'h0}};

	acdr_rx_top acdr_rx_top_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_rxd(i_rxd),
		.i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
		.i_s_axi_wdata(i_s_axi_wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(i_s_axi_wvalid),
		.o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
		.i_s_axi_bready(i_s_axi_bready), .i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
		.o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp),
		.o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready), .o_rx_data(o_rx_data),
		.o_rx_valid(o_rx_valid), .o_frame_err(o_frame_err));
	acdr_uart_tx_model acdr_uart_tx_model_inst (.i_core_clk(i_core_clk), .o_line(i_rxd));

	initial
		forever #25 i_core_clk = ~i_core_clk;

	// Collect every completed frame; the pulse lasts one cycle only
	always @(posedge i_core_clk)
		if (o_rx_valid === 1'h1)
			rxq.push_back({o_frame_err, o_rx_data});

	// Hang guard, well above the expected run length
	always @(posedge i_core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 80000)
		begin
			n_errors++;
			final_report();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t ns: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	// Address and data offered together; bready rises only once the answer shows, so the slave must hold it
	task automatic axi_write(input logic [4:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_s_axi_awaddr <= {3'h0, a};
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= 1'h1;
		i_s_axi_wvalid <= 1'h1;
		do
		begin
			@(posedge i_core_clk);
			if (o_s_axi_awready === 1'h1)
				i_s_axi_awvalid <= 1'h0;
			if (o_s_axi_wready === 1'h1)
				i_s_axi_wvalid <= 1'h0;
			if (o_s_axi_bvalid === 1'h1 && i_s_axi_bready !== 1'h1)
				i_s_axi_bready <= 1'h1;
		end
		while (o_s_axi_bvalid !== 1'h1 || i_s_axi_bready !== 1'h1);
		i_s_axi_bready <= 1'h0;
		resp = o_s_axi_bresp;
	endtask : axi_write

	task automatic axi_read(input logic [4:0] a);
		@(posedge i_core_clk);
		i_s_axi_araddr <= {3'h0, a};
		i_s_axi_arvalid <= 1'h1;
		do
		begin
			@(posedge i_core_clk);
			if (o_s_axi_arready === 1'h1)
				i_s_axi_arvalid <= 1'h0;
			if (o_s_axi_rvalid === 1'h1 && i_s_axi_rready !== 1'h1)
				i_s_axi_rready <= 1'h1;
		end
		while (o_s_axi_rvalid !== 1'h1 || i_s_axi_rready !== 1'h1);
		i_s_axi_rready <= 1'h0;
		rd = o_s_axi_rdata;
		resp = o_s_axi_rresp;
	endtask : axi_read

	// Waits boundedly for the next frame; a missing frame counts as a mismatch
	task automatic expect_frame(input logic [9:0] d, input logic fe);
		repeat (3000)
			if (rxq.size() == 0)
				@(posedge i_core_clk);
		if (rxq.size() == 0)
			check(32'h1, 32'h0);
		else
			check({21'h0, rxq.pop_front()}, {21'h0, fe, d});
	endtask : expect_frame

	// Break at the current rate, then a sync character of the given bit time
	task automatic autobaud(input int sbt, input int extra);
		acdr_uart_tx_model_inst.hold(1'h0, 1792);
		acdr_uart_tx_model_inst.hold(1'h1, 256);
		acdr_uart_tx_model_inst.send(10'h055, 8, sbt, extra, 1'h1, 512);
		rxq.delete();
	endtask : autobaud

	initial
	begin
		repeat (16) @(posedge i_core_clk);
		i_rst_n <= 1'h1;
		// 128 clocks a bit in normal mode, 64 in double speed
		axi_write(OFS_BAUD, 32'h0400);
		foreach (rows[i])
		begin
			n = 5 + ((rows[i].fmt[2:0] > 3'h4) ? 4 : int'(rows[i].fmt[2:0])) + int'(rows[i].fmt[3]);
			bt = (rows[i].mode == MODE_DOUBLE) ? 64 : 128;
			want = rows[i].data & ((10'h1 << n) - 10'h1);
			axi_write(OFS_FORMAT, {28'h0, rows[i].fmt});
			axi_write(OFS_CTRL_TWO, {29'h0, rows[i].mode, 1'h1});
			acdr_uart_tx_model_inst.send(rows[i].data, n, bt, 0, rows[i].stop, 2 * bt);
			expect_frame(want, ~rows[i].stop);
			axi_read(OFS_RXDATA);
			check(rd, {16'h0, 1'h1, ~rows[i].stop, 4'h0, want});
		end
		axi_read(OFS_STATUS);
		check({31'h0, rd[ST_FERR_BIT]}, 32'h1);
		// Short low glitch of four samples must not start a frame
		axi_write(OFS_FORMAT, 32'h3);
		axi_write(OFS_CTRL_TWO, {29'h0, MODE_NORMAL, 1'h1});
		acdr_uart_tx_model_inst.hold(1'h0, 32);
		acdr_uart_tx_model_inst.hold(1'h1, 256);
		acdr_uart_tx_model_inst.send(10'h03C, 8, 128, 0, 1'h1, 256);
		expect_frame(10'h03C, 1'h0);
		// Next start right after the stop votes, twelve samples of stop
		acdr_uart_tx_model_inst.send(10'h081, 8, 128, 0, 1'h1, 96);
		acdr_uart_tx_model_inst.send(10'h07E, 8, 128, 0, 1'h1, 256);
		expect_frame(10'h081, 1'h0);
		expect_frame(10'h07E, 1'h0);
		check(rxq.size(), 32'h0);
		// Automatic baud: in range, out of range, then uneven sync
		axi_write(OFS_CTRL_TWO, {29'h0, MODE_GENERIC, 1'h1});
		autobaud(96, 0);
		axi_read(OFS_BAUD);
		check({31'h0, rd >= 32'h2FD && rd <= 32'h305}, 32'h1);
		base = rd;
		autobaud(10, 0);
		axi_read(OFS_BAUD);
		check(rd, base);
		axi_write(OFS_CTRL_TWO, {29'h0, MODE_CONSTR, 1'h1});
		autobaud(96, 60);
		axi_read(OFS_BAUD);
		check(rd, base);
		axi_read(OFS_STATUS);
		check({30'h0, rd[ST_BRK_BIT], rd[ST_ISF_BIT]}, 32'h3);
		axi_write(OFS_STATUS, 32'hE);
		axi_read(OFS_STATUS);
		check({29'h0, rd[3:1]}, 32'h0);
		// Reset in mid-run returns the registers to their reset values
		@(posedge i_core_clk);
		i_rst_n <= 1'h0;
		repeat (16) @(posedge i_core_clk);
		i_rst_n <= 1'h1;
		axi_read(OFS_BAUD);
		check(rd, {16'h0, BAUD_RESET});
		axi_read(OFS_CTRL_TWO);
		check(rd, {29'h0, CTRL_RESET});
		axi_read(OFS_FORMAT);
		check(rd, {28'h0, FMT_RESET});
		axi_read(5'h14);
		check({resp, rd[29:0]}, {RESP_SLVERR, 30'h0});
		axi_write(5'h18, 32'h1);
		check({30'h0, resp}, {30'h0, RESP_SLVERR});
		final_report();
	end
endmodule : acdr_rx_tb_top
